//--- logic/aux_pkg.sv
// Shared constants for the secondary converter detection block and its host
package aux_pkg;
  // Register map, page 0 except exec and coefficient registers, which are written on page 1
  localparam logic [7:0] ADDR_PAGE = 8'h00;
  localparam logic [7:0] ADDR_EXEC = 8'h01;
  localparam logic [7:0] ADDR_COEF_ADDR = 8'h02;
  localparam logic [7:0] ADDR_COEF_D0 = 8'h04;
  localparam logic [7:0] ADDR_COEF_D1 = 8'h05;
  localparam logic [7:0] ADDR_COEF_D2 = 8'h06;
  localparam logic [7:0] ADDR_INPUT_SEL = 8'h0a;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h2e;
  localparam logic [7:0] ADDR_CH_MODE = 8'h30;
  localparam logic [7:0] ADDR_LOSS_TIME = 8'h33;
  localparam logic [7:0] ADDR_INTERVAL = 8'h36;
  localparam logic [7:0] ADDR_REF_BASE = 8'h38;
  localparam logic [7:0] ADDR_DIFF_BASE = 8'h40;
  localparam logic [7:0] ADDR_LEVEL_BASE = 8'h48;
  localparam logic [7:0] ADDR_DATA_CTRL = 8'h58;
  localparam logic [7:0] ADDR_DATA_HIGH = 8'h59;
  localparam logic [7:0] ADDR_DATA_LOW = 8'h5a;
  localparam logic [7:0] ADDR_INT_CFG = 8'h62;
  localparam logic [7:0] ADDR_POWER_DOWN = 8'h70;
  localparam logic [7:0] PAGE_MAIN = 8'h00;
  localparam logic [7:0] PAGE_COEF = 8'h01;
  localparam logic [7:0] EXEC_GO = 8'h01;
  // Coefficient space addresses
  localparam logic [7:0] COEF_LOSS_THR = 8'h2c;
  localparam logic [7:0] COEF_RESUME_THR = 8'h2d;
  // Field positions
  localparam int DIRECT_READ_BIT = 7;
  localparam int LATCH_REQ_BIT = 0;
  localparam int LATCHED_BIT = 1;
  localparam int STICKY_BIT = 0;
  localparam int SLEEP_BIT = 0;
  localparam int ST_RESUME = 0;
  localparam int ST_LOSS = 1;
  localparam int ST_DC = 2;
  localparam logic [2:0] STATUS_ALL = 3'h7;
  // Values after reset
  localparam logic [7:0] INPUT_SEL_RESET = 8'h00;
  localparam logic [7:0] CH_MODE_RESET = 8'h00;
  localparam logic [7:0] LOSS_TIME_RESET = 8'h01;
  localparam logic [7:0] INTERVAL_RESET = 8'h10;
  localparam logic [7:0] INT_CFG_RESET = 8'h00;
  localparam logic [7:0] POWER_DOWN_RESET = 8'h00;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  // -57 dBFS and -60 dBFS as 24-bit magnitudes
  localparam logic [23:0] RESUME_THR_RESET = 24'h002e49;
  localparam logic [23:0] LOSS_THR_RESET = 24'h0020c5;
  // Timing
  localparam longint CLK_HZ = 200_000_000;
  localparam longint PULSE_MS = 1;
  localparam longint PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
  localparam longint SECOND_CYCLES = CLK_HZ;
  localparam longint DWELL_UNIT_MS = 40;
  localparam longint DWELL_UNIT_CYCLES = CLK_HZ / 1000 * DWELL_UNIT_MS;
  localparam longint NOMINAL_FS_HZ = 48000;
  localparam longint SAMPLES_PER_MIN = NOMINAL_FS_HZ * 60;
  localparam logic [2:0] LOSS_MIN_MINUTES = 3'h1;
  localparam logic [2:0] LOSS_MAX_MINUTES = 3'h5;
  localparam int COEF_STEPS = 7;
endpackage

//--- logic/aux_if.sv
// Register bus and interrupt line between host and detection device
interface aux_if;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic int_req;
  logic clk_run;
  modport device (input reg_wr, reg_rd, reg_addr, reg_wdata, clk_run,
                  output reg_rdata, reg_rvalid, int_req);
  modport host (output reg_wr, reg_rd, reg_addr, reg_wdata, clk_run,
                input reg_rdata, reg_rvalid, int_req);
endinterface

//--- logic/aux_detect_device.sv
// Detection logic of the secondary converter: dc change, loss and resume
// How it works
// - Host may flatten response via biquad coefficients; coefficient writes here set only the loss and resume thresholds
// - Dc detection uses unfiltered converter samples
// - Separate reference and difference per input
// - Dc change past difference raises interrupt
// - Sleep scanning of inputs runs unattended
// - Active mode host selects input by register
// - Eight-bit readback needs direct-read bit, control mode
// - Latch request captures 16-bit two's-complement data
// - Device never changes power state itself
// - Resume threshold resets to -57 dBFS
// - Resume detection only while asleep
// - Host sleeps device by clock stop or register
// - Resume pulses 1 ms, repeats every X s
// - Loss interrupt after level low for timeout
// - Loss re-signals each interval until cleared
// - Loss timeout one to five minutes
// - Loss timeout counts samples, not time
// - Interrupt output pulsed or sticky by config
// - Sleep scan converts all eight round-robin
// - Dwell 160, 80 or 40 ms per channel
// - Coefficient written by paged indirect sequence
// - Writing status clears flagged interrupt bits
module aux_detect_device
  import aux_pkg::*;
#(
  parameter int unsigned PULSE_LEN = 32'(PULSE_CYCLES),
  parameter int unsigned SECOND_LEN = 32'(SECOND_CYCLES),
  parameter int unsigned DWELL_UNIT = 32'(DWELL_UNIT_CYCLES),
  parameter int unsigned MINUTE_SAMPLES = 32'(SAMPLES_PER_MIN)
) (
  input wire logic i_core_clk,          // Core clock, 200 MHz
  input wire logic i_reset_n,           // Asynchronous reset, active low
  aux_if.device bus,                    // Register bus and interrupt
  input wire logic i_aux_valid,         // Secondary sample strobe
  input wire logic [15:0] i_aux_raw,    // Unfiltered sample, signed
  input wire logic [23:0] i_aux_energy, // Filtered level magnitude
  input wire logic i_main_valid,        // Main converter sample strobe
  input wire logic [23:0] i_main_level, // Main converter level magnitude
  output logic [2:0] o_aux_channel,     // Input routed to the converter
  output logic o_sleep                  // Device is in the sleep state
);
  typedef enum logic [1:0] {
    DWELL_160 = 2'b00,
    DWELL_80 = 2'b01,
    DWELL_40 = 2'b10
  } dwell_e;
  typedef struct packed {
    logic [7:0] page, input_sel, ch_mode, loss_time, interval;
    logic [7:0] int_cfg, power_down, coef_addr, rdata;
    logic direct_read, latched, int_out, rvalid;
    logic [15:0] data;
    logic [2:0] status, scan_ch;
    logic [7:0][7:0] ref_level, diff_level, level;
    logic [23:0] resume_thr, loss_thr, coef_data;
    logic [31:0] dwell_cnt, loss_cnt, repeat_cnt, pulse_cnt;
  } state_s;
  state_s st;
  state_s next_st;
  logic sleep, repeat_on;
  logic [2:0] chan, minutes, set_bits, clr_bits;
  logic [7:0] sample_level, delta, rd_value;
  logic [31:0] loss_limit, dwell_limit, repeat_limit;
  // power state follows host actions only
  // stopped clocks or register bit mean sleep
  assign sleep = ~bus.clk_run | st.power_down[SLEEP_BIT];
  // active channel comes from input select, or from the scan counter while asleep
  assign chan = sleep ? st.scan_ch : st.input_sel[2:0];
  assign sample_level = {~i_aux_raw[15], i_aux_raw[14:8]};
  assign delta = (sample_level > st.ref_level[chan]) ?
                 sample_level - st.ref_level[chan] :
                 st.ref_level[chan] - sample_level;
  assign minutes = (st.loss_time[2:0] < LOSS_MIN_MINUTES) ? LOSS_MIN_MINUTES :
                   (st.loss_time[2:0] > LOSS_MAX_MINUTES) ? LOSS_MAX_MINUTES :
                   st.loss_time[2:0];
  assign loss_limit = 32'(minutes) * MINUTE_SAMPLES;
  always_comb begin
    case (dwell_e'(st.interval[1:0]))
      DWELL_160: dwell_limit = DWELL_UNIT << 2;
      DWELL_80: dwell_limit = DWELL_UNIT << 1;
      DWELL_40: dwell_limit = DWELL_UNIT;
      default: dwell_limit = DWELL_UNIT << 2;
    endcase
  end
  // Repeat interval in seconds, zero treated as one
  assign repeat_limit = (st.interval[7:4] == 4'h0) ? SECOND_LEN :
                        32'(st.interval[7:4]) * SECOND_LEN;
  always_comb begin
    rd_value = 8'h00;
    case (bus.reg_addr)
      ADDR_PAGE: rd_value = st.page;
      ADDR_COEF_ADDR: rd_value = st.coef_addr;
      ADDR_COEF_D0: rd_value = st.coef_data[23:16];
      ADDR_COEF_D1: rd_value = st.coef_data[15:8];
      ADDR_COEF_D2: rd_value = st.coef_data[7:0];
      ADDR_INPUT_SEL: rd_value = st.input_sel;
      ADDR_INT_STATUS: rd_value = {5'h00, st.status};
      ADDR_CH_MODE: rd_value = st.ch_mode;
      ADDR_LOSS_TIME: rd_value = st.loss_time;
      ADDR_INTERVAL: rd_value = st.interval;
      ADDR_DATA_CTRL: rd_value = {st.direct_read, 5'h00, st.latched, 1'b0};
      // latched word split high then low
      ADDR_DATA_HIGH: rd_value = st.data[15:8];
      ADDR_DATA_LOW: rd_value = st.data[7:0];
      ADDR_INT_CFG: rd_value = st.int_cfg;
      ADDR_POWER_DOWN: rd_value = st.power_down;
      default: begin
        if (bus.reg_addr[7:3] == ADDR_REF_BASE[7:3]) begin
          rd_value = st.ref_level[bus.reg_addr[2:0]];
        end else if (bus.reg_addr[7:3] == ADDR_DIFF_BASE[7:3]) begin
          rd_value = st.diff_level[bus.reg_addr[2:0]];
        end else if (bus.reg_addr[7:3] == ADDR_LEVEL_BASE[7:3]) begin
          rd_value = st.level[bus.reg_addr[2:0]];
        end
      end
    endcase
  end
  always_comb begin
    next_st = st;
    set_bits = 3'h0;
    clr_bits = 3'h0;
    next_st.rvalid = bus.reg_rd;
    if (bus.reg_rd) begin
      next_st.rdata = (bus.reg_addr == ADDR_PAGE || st.page == PAGE_MAIN) ?
                      rd_value : 8'h00;
    end
    if (bus.reg_wr) begin
      if (bus.reg_addr == ADDR_PAGE) begin
        next_st.page = bus.reg_wdata;
      end else if (st.page == PAGE_COEF) begin
        case (bus.reg_addr)
          ADDR_COEF_ADDR: next_st.coef_addr = bus.reg_wdata;
          ADDR_COEF_D0: next_st.coef_data[23:16] = bus.reg_wdata;
          ADDR_COEF_D1: next_st.coef_data[15:8] = bus.reg_wdata;
          ADDR_COEF_D2: next_st.coef_data[7:0] = bus.reg_wdata;
          ADDR_EXEC: begin
            if (bus.reg_wdata == EXEC_GO) begin
              if (st.coef_addr == COEF_RESUME_THR) begin
                next_st.resume_thr = st.coef_data;
              end else if (st.coef_addr == COEF_LOSS_THR) begin
                next_st.loss_thr = st.coef_data;
              end
            end
          end
          default: next_st.page = st.page;
        endcase
      end else begin
        case (bus.reg_addr)
          ADDR_INPUT_SEL: next_st.input_sel = bus.reg_wdata;
          ADDR_INT_STATUS: clr_bits = bus.reg_wdata[2:0];
          ADDR_CH_MODE: next_st.ch_mode = bus.reg_wdata;
          ADDR_LOSS_TIME: next_st.loss_time = bus.reg_wdata;
          ADDR_INTERVAL: next_st.interval = bus.reg_wdata;
          ADDR_DATA_CTRL: begin
            next_st.direct_read = bus.reg_wdata[DIRECT_READ_BIT];
            if (bus.reg_wdata[LATCH_REQ_BIT]) begin
              next_st.data = i_aux_raw;
              next_st.latched = 1'b1;
            end
          end
          ADDR_INT_CFG: next_st.int_cfg = bus.reg_wdata;
          ADDR_POWER_DOWN: next_st.power_down = bus.reg_wdata;
          default: begin
            if (bus.reg_addr[7:3] == ADDR_REF_BASE[7:3]) begin
              next_st.ref_level[bus.reg_addr[2:0]] = bus.reg_wdata;
            end else if (bus.reg_addr[7:3] == ADDR_DIFF_BASE[7:3]) begin
              next_st.diff_level[bus.reg_addr[2:0]] = bus.reg_wdata;
            end
          end
        endcase
      end
    end
    if (sleep) begin
      if (st.dwell_cnt + 32'h1 >= dwell_limit) begin
        next_st.dwell_cnt = 32'h0;
        next_st.scan_ch = st.scan_ch + 3'h1;
      end else begin
        next_st.dwell_cnt = st.dwell_cnt + 32'h1;
      end
    end else begin
      next_st.dwell_cnt = 32'h0;
    end
    if (i_aux_valid) begin
      if (st.ch_mode[chan]) begin
        // readback updated when direct read enabled
        if (st.direct_read) begin
          next_st.level[chan] = sample_level;
        end
        if (delta > st.diff_level[chan]) begin
          set_bits[ST_DC] = 1'b1;
        end
      end else if (sleep && i_aux_energy > st.resume_thr) begin
        set_bits[ST_RESUME] = 1'b1;
      end
    end
    // count low main samples while active
    if (sleep || clr_bits[ST_LOSS]) begin
      next_st.loss_cnt = 32'h0;
    end else if (i_main_valid) begin
      if (i_main_level >= st.loss_thr) begin
        next_st.loss_cnt = 32'h0;
      end else if (st.loss_cnt + 32'h1 >= loss_limit) begin
        next_st.loss_cnt = 32'h0;
        set_bits[ST_LOSS] = 1'b1;
      end else begin
        next_st.loss_cnt = st.loss_cnt + 32'h1;
      end
    end
    // Set wins over a clear in the same cycle
    next_st.status = (st.status & ~clr_bits) | set_bits;
    repeat_on = (st.status[ST_RESUME] & sleep) | (st.status[ST_LOSS] & ~sleep);
    if (!repeat_on || set_bits != 3'h0) begin
      next_st.repeat_cnt = 32'h0;
    end else if (st.repeat_cnt + 32'h1 >= repeat_limit) begin
      next_st.repeat_cnt = 32'h0;
      next_st.pulse_cnt = PULSE_LEN;
    end else begin
      next_st.repeat_cnt = st.repeat_cnt + 32'h1;
    end
    if (set_bits != 3'h0) begin
      next_st.pulse_cnt = PULSE_LEN;
    end else if (st.pulse_cnt != 32'h0 && next_st.repeat_cnt != 32'h0) begin
      next_st.pulse_cnt = st.pulse_cnt - 32'h1;
    end else if (st.pulse_cnt != 32'h0 && repeat_on) begin
      next_st.pulse_cnt = st.pulse_cnt;
    end else if (st.pulse_cnt != 32'h0) begin
      next_st.pulse_cnt = st.pulse_cnt - 32'h1;
    end
    next_st.int_out = st.int_cfg[STICKY_BIT] ? (next_st.status != 3'h0) :
                      (next_st.pulse_cnt != 32'h0);
  end
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
      st.page <= PAGE_MAIN;
      st.input_sel <= INPUT_SEL_RESET;
      st.ch_mode <= CH_MODE_RESET;
      st.loss_time <= LOSS_TIME_RESET;
      st.interval <= INTERVAL_RESET;
      st.int_cfg <= INT_CFG_RESET;
      st.power_down <= POWER_DOWN_RESET;
      st.level <= {8{LEVEL_RESET}};
      st.resume_thr <= RESUME_THR_RESET;
      st.loss_thr <= LOSS_THR_RESET;
    end else begin
      st <= next_st;
    end
  end
  assign bus.reg_rdata = st.rdata;
  assign bus.reg_rvalid = st.rvalid;
  assign bus.int_req = st.int_out;
  assign o_aux_channel = chan;
  assign o_sleep = sleep;
endmodule

//--- logic/aux_detect_host.sv
// Host end: register access, coefficient sequence, input stepping, sleep
module aux_detect_host
  import aux_pkg::*;
(
  input wire logic i_core_clk,         // Core clock, 200 MHz
  input wire logic i_reset_n,          // Asynchronous reset, active low
  aux_if.host bus,                     // Register bus and interrupt
  input wire logic i_wr_valid,         // Plain register write request
  input wire logic [7:0] i_wr_addr,    // Write address
  input wire logic [7:0] i_wr_data,    // Write data
  input wire logic i_rd_valid,         // Register read request
  input wire logic [7:0] i_rd_addr,    // Read address
  input wire logic i_coef_valid,       // Coefficient write request
  input wire logic [7:0] i_coef_addr,  // Coefficient space address
  input wire logic [23:0] i_coef_data, // Coefficient value
  input wire logic i_step_input,       // Step active input selection
  input wire logic i_clear_int,        // Clear all interrupt flags
  input wire logic i_sleep,            // Stop audio clocks to sleep
  output logic o_ready,                // Requests taken when high
  output logic [7:0] o_rd_data,        // Read result
  output logic o_rd_done,              // Read result valid, one cycle
  output logic o_int                   // Device interrupt line
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_COEF = 2'b10
  } host_state_e;

  typedef struct packed {
    host_state_e state;
    logic [2:0] step;
    logic [7:0] caddr;
    logic [23:0] cdata;
    logic [2:0] chan;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rd_done;
    logic clk_run;
  } host_s;

  host_s st;
  host_s next_st;

  always_comb begin
    next_st = st;
    next_st.wr = 1'b0;
    next_st.rd = 1'b0;
    next_st.rd_done = bus.reg_rvalid;
    if (bus.reg_rvalid) begin
      next_st.rdata = bus.reg_rdata;
    end
    next_st.clk_run = ~i_sleep;
    case (st.state)
      ST_IDLE: begin
        if (i_coef_valid) begin
          next_st.state = ST_COEF;
          next_st.step = 3'h0;
          next_st.caddr = i_coef_addr;
          next_st.cdata = i_coef_data;
        end else if (i_step_input) begin
          next_st.chan = st.chan + 3'h1;
          next_st.wr = 1'b1;
          next_st.addr = ADDR_INPUT_SEL;
          next_st.wdata = {5'h00, st.chan + 3'h1};
        end else if (i_clear_int) begin
          next_st.wr = 1'b1;
          next_st.addr = ADDR_INT_STATUS;
          next_st.wdata = {5'h00, STATUS_ALL};
        end else if (i_wr_valid) begin
          next_st.wr = 1'b1;
          next_st.addr = i_wr_addr;
          next_st.wdata = i_wr_data;
        end else if (i_rd_valid) begin
          next_st.rd = 1'b1;
          next_st.addr = i_rd_addr;
        end
      end
      ST_COEF: begin
        // page, address, three bytes, execute, page back
        next_st.wr = 1'b1;
        next_st.step = st.step + 3'h1;
        case (st.step)
          3'h0: {next_st.addr, next_st.wdata} = {ADDR_PAGE, PAGE_COEF};
          3'h1: {next_st.addr, next_st.wdata} = {ADDR_COEF_ADDR, st.caddr};
          3'h2: {next_st.addr, next_st.wdata} =
                {ADDR_COEF_D0, st.cdata[23:16]};
          3'h3: {next_st.addr, next_st.wdata} = {ADDR_COEF_D1, st.cdata[15:8]};
          3'h4: {next_st.addr, next_st.wdata} = {ADDR_COEF_D2, st.cdata[7:0]};
          3'h5: {next_st.addr, next_st.wdata} = {ADDR_EXEC, EXEC_GO};
          default: begin
            {next_st.addr, next_st.wdata} = {ADDR_PAGE, PAGE_MAIN};
            next_st.state = ST_IDLE;
          end
        endcase
      end
      default: next_st.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
      st.state <= ST_IDLE;
      st.clk_run <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign bus.reg_wr = st.wr;
  assign bus.reg_rd = st.rd;
  assign bus.reg_addr = st.addr;
  assign bus.reg_wdata = st.wdata;
  assign bus.clk_run = st.clk_run;
  assign o_ready = (st.state == ST_IDLE);
  assign o_rd_data = st.rdata;
  assign o_rd_done = st.rd_done;
  assign o_int = bus.int_req;
endmodule

//--- tb/aux_detect_props.sv
// Assertions on the register bus and interrupt line between both ends
module aux_detect_props
  import aux_pkg::*;
(
  input wire logic i_core_clk, // Core clock
  input wire logic i_reset_n, // Reset, active low
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic reg_rvalid, // Read data valid
  input wire logic int_req, // Interrupt line
  input wire logic clk_run // Audio clocks running
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] page;
  logic sticky;
  logic quiet;
  logic int_d;
  logic [7:0] gap;
  wire logic rise = int_req && !int_d;
  // Shadow of page and mode, cycles since the last interrupt edge
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      page <= PAGE_MAIN;
      sticky <= 1'b0;
      quiet <= 1'b0;
      int_d <= 1'b0;
      gap <= 8'h00;
    end else begin
      int_d <= int_req;
      gap <= rise ? 8'h01 : gap + {7'h00, gap != 8'hff};
      if (reg_wr && reg_addr == ADDR_PAGE)
        page <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_INT_CFG && page == PAGE_MAIN)
        sticky <= reg_wdata[STICKY_BIT];
      if (reg_wr || clk_run)
        quiet <= 1'b0;
      else if (rise)
        quiet <= 1'b1;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  let wr_at(a) = reg_wr && reg_addr == a;
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered after one cycle");
  rd_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read data valid without a read");
  data_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data changed outside an answer");
  input_range_a: assert property (wr_at(ADDR_INPUT_SEL)
    && page == PAGE_MAIN |-> reg_wdata[7:3] == 5'h00)
    else $error("input selection out of range");
  pulse_len_a: assert property (!sticky && $rose(int_req)
    |-> int_req [*4] ##1 !int_req)
    else $error("interrupt pulse length wrong");
  sticky_hold_a: assert property (sticky && int_req && !reg_wr
    && !$past(reg_wr) && $stable(clk_run) |=> int_req)
    else $error("sticky interrupt dropped without clearing");
  clear_drop_a: assert property (sticky && clk_run
    && wr_at(ADDR_INT_STATUS) && page == PAGE_MAIN |-> ##[1:3] !int_req)
    else $error("interrupt not cleared by status write");
  resume_gap_a: assert property (rise && quiet
    |-> gap >= 8'h27 && gap <= 8'h29)
    else $error("resume interrupt repeat interval wrong");
  coef_walk_a: assert property (wr_at(ADDR_PAGE)
    && reg_wdata == PAGE_COEF |=> wr_at(ADDR_COEF_ADDR)
    ##1 wr_at(ADDR_COEF_D0) ##1 wr_at(ADDR_COEF_D1) ##1 wr_at(ADDR_COEF_D2)
    ##1 wr_at(ADDR_EXEC) && reg_wdata == EXEC_GO
    ##1 wr_at(ADDR_PAGE) && reg_wdata == PAGE_MAIN)
    else $error("coefficient write sequence broken");
  cover property (rise && quiet);
  cover property (wr_at(ADDR_PAGE) && reg_wdata == PAGE_COEF);
  cover property (sticky && int_req);
  cover property (reg_rvalid);
endmodule

//--- tb/aux_adc_level_and_signal_detect_bench.sv
// Bench joining host and device ends, with a register model and checks
module aux_adc_level_and_signal_detect_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import aux_pkg::*;
  logic i_core_clk, i_reset_n, i_sleep, i_aux_valid, i_main_valid;
  logic i_wr_valid, i_rd_valid, i_coef_valid, i_step_input, i_clear_int;
  logic [15:0] i_aux_raw;
  logic [23:0] i_aux_energy, i_main_level, i_coef_data;
  logic [7:0] i_wr_addr, i_wr_data, i_rd_addr, i_coef_addr, o_rd_data;
  logic [2:0] o_aux_channel, c0;
  logic o_sleep, o_ready, o_rd_done, o_int;
  logic [7:0] m [256];
  logic [7:0] ra [8] = '{ADDR_INPUT_SEL, ADDR_CH_MODE, ADDR_LOSS_TIME,
    ADDR_INTERVAL, ADDR_INT_CFG, ADDR_POWER_DOWN, ADDR_INT_STATUS, 8'h20};
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int seed = 32'h6dab;
  int i, t, n;
  aux_if bus_if ();
  aux_detect_device #(.PULSE_LEN(4), .SECOND_LEN(40), .DWELL_UNIT(8),
    .MINUTE_SAMPLES(5)) u_aux_detect_device (.i_core_clk, .i_reset_n,
    .bus(bus_if.device), .i_aux_valid, .i_aux_raw, .i_aux_energy,
    .i_main_valid, .i_main_level, .o_aux_channel, .o_sleep);
  aux_detect_host u_aux_detect_host (.i_core_clk, .i_reset_n,
    .bus(bus_if.host), .i_wr_valid, .i_wr_addr, .i_wr_data, .i_rd_valid,
    .i_rd_addr, .i_coef_valid, .i_coef_addr, .i_coef_data, .i_step_input,
    .i_clear_int, .i_sleep, .o_ready, .o_rd_data, .o_rd_done, .o_int);
  aux_detect_props u_aux_detect_props (.i_core_clk, .i_reset_n,
    .reg_wr(bus_if.reg_wr), .reg_rd(bus_if.reg_rd),
    .reg_addr(bus_if.reg_addr), .reg_wdata(bus_if.reg_wdata),
    .reg_rdata(bus_if.reg_rdata), .reg_rvalid(bus_if.reg_rvalid),
    .int_req(bus_if.int_req), .clk_run(bus_if.clk_run));
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  task stop_test;
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Kinds: 0 write, 1 read, 2 coefficient, 3 step, 4 clear
  task req(input int k, input logic [7:0] a, input logic [23:0] d);
    @(negedge i_core_clk);
    while (o_ready !== 1'b1) @(negedge i_core_clk);
    @(posedge i_core_clk);
    {i_wr_valid, i_rd_valid, i_coef_valid, i_step_input, i_clear_int}
      <= 5'(5'h10 >> k);
    i_wr_addr <= a;
    i_rd_addr <= a;
    i_coef_addr <= a;
    i_wr_data <= d[7:0];
    i_coef_data <= d;
    @(posedge i_core_clk);
    {i_wr_valid, i_rd_valid, i_coef_valid, i_step_input, i_clear_int}
      <= 5'h00;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    req(0, a, {16'h0000, d});
    m[a] = d;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    req(1, a, 24'h000000);
    for (int k = 0; k < 8 && o_rd_done !== 1'b1; k++) @(negedge i_core_clk);
    chk(o_rd_done, 1'b1);
    chk(o_rd_data, e);
  endtask
  task feed(input logic a, input logic [15:0] r, input logic [23:0] e,
      input logic [23:0] l);
    @(posedge i_core_clk);
    i_aux_valid <= a;
    i_main_valid <= !a;
    i_aux_raw <= r;
    i_aux_energy <= e;
    i_main_level <= l;
    @(posedge i_core_clk);
    i_aux_valid <= 1'b0;
    i_main_valid <= 1'b0;
    repeat (3) @(negedge i_core_clk);
  endtask
  task next_ch(output int k);
    logic [2:0] c;
    c = o_aux_channel;
    k = 0;
    while (o_aux_channel === c && k < 200) begin
      @(negedge i_core_clk);
      k++;
    end
  endtask
  initial begin
    {i_reset_n, i_sleep, i_aux_valid, i_main_valid, i_wr_valid} = 5'h00;
    {i_rd_valid, i_coef_valid, i_step_input, i_clear_int} = 4'h0;
    {i_aux_raw, i_aux_energy, i_main_level, i_coef_data} = 88'h0;
    {i_wr_addr, i_wr_data, i_rd_addr, i_coef_addr} = 32'h0;
    foreach (m[k]) m[k] = 8'h00;
    m[ADDR_LOSS_TIME] = LOSS_TIME_RESET;
    m[ADDR_INTERVAL] = INTERVAL_RESET;
    repeat (3) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    foreach (ra[k]) rd(ra[k], m[ra[k]]);
    req(0, 8'h20, 24'h0000ff);
    rd(8'h20, 8'h00);
    for (i = 0; i < 16; i++) wr(ADDR_REF_BASE + 8'(i), 8'($random(seed)));
    for (i = 0; i < 16; i++)
      rd(ADDR_REF_BASE + 8'(i), m[ADDR_REF_BASE + i]);
    wr(ADDR_INPUT_SEL, 8'h07);
    req(3, 8'h00, 24'h000000);
    rd(ADDR_INPUT_SEL, 8'h01);
    chk(o_aux_channel, 3'h1);
    feed(1'b1, 16'hf00d, 24'h000000, 24'h000000);
    wr(ADDR_DATA_CTRL, 8'h81);
    rd(ADDR_DATA_CTRL, 8'h82);
    rd(ADDR_DATA_HIGH, 8'hf0);
    rd(ADDR_DATA_LOW, 8'h0d);
    wr(ADDR_INPUT_SEL, 8'h03);
    wr(ADDR_CH_MODE, 8'h08);
    wr(ADDR_REF_BASE + 8'h03, 8'h92);
    wr(ADDR_DIFF_BASE + 8'h03, 8'h10);
    feed(1'b1, 16'h1200, 24'h000000, 24'h000000);
    rd(ADDR_LEVEL_BASE + 8'h03, 8'h92);
    feed(1'b1, 16'h2200, 24'h000000, 24'h000000);
    rd(ADDR_INT_STATUS, 8'h00);
    feed(1'b1, 16'h2300, 24'h000000, 24'h000000);
    rd(ADDR_INT_STATUS, 8'(1 << ST_DC));
    req(4, 8'h00, 24'h000000);
    rd(ADDR_INT_STATUS, 8'h00);
    wr(ADDR_CH_MODE, 8'h00);
    wr(ADDR_INT_CFG, 8'h01);
    for (t = 1; t <= 2; t++) begin
      wr(ADDR_LOSS_TIME, 8'(t));
      feed(1'b0, 16'h0000, 24'h000000, LOSS_THR_RESET);
      repeat (5 * t - 1) feed(1'b0, 16'h0000, 24'h000000, LOSS_THR_RESET - 1);
      chk(o_int, 1'b0);
      feed(1'b0, 16'h0000, 24'h000000, LOSS_THR_RESET - 1);
      chk(o_int, 1'b1);
      rd(ADDR_INT_STATUS, 8'(1 << ST_LOSS));
      req(4, 8'h00, 24'h000000);
      rd(ADDR_INT_STATUS, 8'h00);
      chk(o_int, 1'b0);
    end
    wr(ADDR_INT_CFG, 8'h00);
    @(posedge i_core_clk);
    i_sleep <= 1'b1;
    feed(1'b1, 16'h0000, RESUME_THR_RESET, 24'h000000);
    rd(ADDR_INT_STATUS, 8'h00);
    feed(1'b1, 16'h0000, RESUME_THR_RESET + 1, 24'h000000);
    rd(ADDR_INT_STATUS, 8'(1 << ST_RESUME));
    repeat (100) @(negedge i_core_clk);
    chk(o_sleep, 1'b1);
    req(4, 8'h00, 24'h000000);
    req(2, COEF_RESUME_THR, 24'h040c37);
    @(negedge i_core_clk);
    chk(o_ready, 1'b0);
    // Let the whole indirect sequence land before sampling
    repeat (8) @(negedge i_core_clk);
    feed(1'b1, 16'h0000, 24'h040c37, 24'h000000);
    rd(ADDR_INT_STATUS, 8'h00);
    feed(1'b1, 16'h0000, 24'h040c38, 24'h000000);
    rd(ADDR_INT_STATUS, 8'(1 << ST_RESUME));
    req(4, 8'h00, 24'h000000);
    @(posedge i_core_clk);
    i_sleep <= 1'b0;
    feed(1'b1, 16'h0000, 24'hffffff, 24'h000000);
    rd(ADDR_INT_STATUS, 8'h00);
    chk(o_sleep, 1'b0);
    wr(ADDR_POWER_DOWN, 8'h01);
    repeat (3) @(negedge i_core_clk);
    chk(o_sleep, 1'b1);
    for (t = 0; t < 3; t++) begin
      wr(ADDR_INTERVAL, 8'h10 | 8'(t));
      next_ch(n);
      c0 = o_aux_channel;
      next_ch(n);
      chk(n, 32 >> t);
      chk(o_aux_channel, 3'(c0 + 3'h1));
    end
    wr(ADDR_POWER_DOWN, 8'h00);
    stop_test();
  end
endmodule
